// ==== core/vpf_pkg.sv ====
// Shared constants, operation codes and carrier structs of the vector
// predication and flag logic.
// Assumes a single core clock domain and one in-order request stream.
package vpf_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int VPF_LANES = 8;
   localparam int VPF_EW    = 16;
   localparam int VPF_VW    = VPF_LANES * VPF_EW;
   localparam int VPF_PW    = VPF_LANES * 2;
   localparam int VPF_RW    = 64;
   localparam int VPF_PRED_LOW_REGS = 8;

   // ---------------------------------------------------------------
   // Register map and fields
   // ---------------------------------------------------------------
   localparam logic [3:0] VPF_REG_CTRL  = 4'h0;
   localparam logic [3:0] VPF_REG_FLAGS = 4'h4;
   localparam int VPF_CTRL_AHP   = 0;
   localparam int VPF_CTRL_DIT   = 1;
   localparam int VPF_CTRL_BF_LO = 4;
   localparam int VPF_CTRL_BF_HI = 7;
   localparam logic [7:0]  VPF_CTRL_RST = 8'h00;
   localparam logic [3:0]  VPF_FLAGS_RST = 4'h0;
   localparam logic [15:0] VPF_FM_RST = 16'hFFFF;
   localparam int VPF_FN = 3;
   localparam int VPF_FZ = 2;
   localparam int VPF_FC = 1;
   localparam int VPF_FV = 0;
   localparam int VPF_FP_SIGN = 15;

   // Scalar result widths
   localparam logic [1:0] VPF_SW8  = 2'h0;
   localparam logic [1:0] VPF_SW16 = 2'h1;
   localparam logic [1:0] VPF_SW32 = 2'h2;

   // ---------------------------------------------------------------
   // Operation codes
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      VPF_OP_NOP    = 4'h0,
      VPF_OP_RDFM   = 4'h1,
      VPF_OP_RDFMS  = 4'h2,
      VPF_OP_WRFM   = 4'h3,
      VPF_OP_SETFM  = 4'h4,
      VPF_OP_FFLOAD = 4'h5,
      VPF_OP_PREDICATE_TEST  = 4'h6,
      VPF_OP_CMPEQ  = 4'h7,
      VPF_OP_VADD   = 4'h8,
      VPF_OP_FNEG16 = 4'h9,
      VPF_OP_BFNEG  = 4'hA,
      VPF_OP_LASTB  = 4'hB,
      VPF_OP_CTEQ   = 4'hC,
      VPF_OP_CTNE   = 4'hD
   } vpf_op_e;

   typedef struct packed {
      logic              valid;
      vpf_op_e           op;
      logic              predicated;
      logic              zeroing;
      logic              set_flags;
      logic [3:0]        pg_idx;
      logic [1:0]        swidth;
      logic [VPF_PW-1:0] pg;
      logic [VPF_PW-1:0] pa;
      logic [VPF_PW-1:0] pd_old;
      logic [VPF_VW-1:0] va;
      logic [VPF_VW-1:0] vb;
      logic [VPF_VW-1:0] vd_old;
      logic [VPF_RW-1:0] xa;
      logic [VPF_RW-1:0] xb;
   } vpf_req_s;

   typedef struct packed {
      logic              valid;
      logic              illegal;
      logic [VPF_VW-1:0] vec;
      logic [VPF_PW-1:0] pred;
      logic [VPF_RW-1:0] scalar;
      logic [3:0]        flags;
   } vpf_rsp_s;

endpackage

// ==== core/vpf_lane.sv ====
// One destination lane: active lanes take the new value, inactive lanes
// are zeroed or keep the old value.
// Assumes purely combinational use inside the core.
`timescale 1ns/1ps
`default_nettype none
module vpf_lane
#(
   parameter int W = 16
)
(
   input  wire logic         act_in,
   input  wire logic         zero_in,
   input  wire logic [W-1:0] new_in,
   input  wire logic [W-1:0] old_in,
   output logic      [W-1:0] lane_out
);
   wire logic [W-1:0] idle_val;

   assign idle_val = zero_in ? '0 : old_in;
   assign lane_out = act_in ? new_in : idle_val;

endmodule
`default_nettype wire

// ==== core/vpf_flag_gen.sv ====
// Condition flags from a per-lane boolean result and an active mask.
// Assumes lane 0 is the first lane in element order.
`timescale 1ns/1ps
`default_nettype none
module vpf_flag_gen
#(
   parameter int LANES = 8
)
(
   input  wire logic [LANES-1:0] res_in,
   input  wire logic [LANES-1:0] act_in,
   output logic      [3:0]       condition_flags_out
);
   logic first_v;
   logic last_v;
   logic seen_f;
   logic seen_l;

   always_comb
   begin
      first_v = 1'b0;
      last_v  = 1'b0;
      seen_f  = 1'b0;
      seen_l  = 1'b0;
      for (int i = 0; i < LANES; i++)
      begin
         if (act_in[i] && !seen_f)
         begin
            first_v = res_in[i];
            seen_f  = 1'b1;
         end
         if (act_in[LANES-1-i] && !seen_l)
         begin
            last_v = res_in[LANES-1-i];
            seen_l = 1'b1;
         end
      end
   end

   assign condition_flags_out[3] = first_v;
   assign condition_flags_out[2] = ~|(res_in & act_in);
   assign condition_flags_out[1] = ~last_v;
   assign condition_flags_out[0] = 1'b0;

endmodule
`default_nettype wire

// ==== core/vpf_core.sv ====
// Execution core: fault mask register, lane predication, scalar placement,
// half-precision and bfloat16 gating, condition flags and fixed timing.
// Assumes requests and register strobes come from logic on clk_in.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Only fault-mask reads read mask directly
// - Only write/set-all ops write mask directly
// - Mask accesses occur in program order
// - Scalar result lands in low N bits
// - Bits above N up to RW cleared
// - Alternative half-precision bit is ignored
// - Half precision uses IEEE encoding only
// - Bfloat16 needs nonzero feature field
// - Governing TRUE makes lane active
// - Governing FALSE makes lane inactive
// - Predicated ops touch active lanes only
// - Unpredicated ops process every lane
// - Inactive lanes zeroed or merged
// - Many ops accept only low eight predicates
// - Governing predicate picks flag lanes
// - N set when first active lane TRUE
// - Z cleared when any active TRUE
// - C cleared when last active TRUE
// - V always cleared by default ops
// - Test and flagged read use source
// - Compare-terminate flags from scalar sources
// - Unpredicated timing data-independent under control
// - Predicated timing fixed for fixed predicate
module vpf_core
   import vpf_pkg::*;
#(
   parameter int         LANES      = vpf_pkg::VPF_LANES,
   parameter int         EW         = vpf_pkg::VPF_EW,
   parameter bit         HAS_GEN2   = 1'b1,
   parameter logic [3:0] BF16_RESET = 4'h1
)
(
   input  wire logic                     clk_in,
   input  wire logic                     resetn_in,
   input  wire logic [3:0]               reg_addr_in,
   input  wire logic [31:0]              reg_wdata_in,
   input  wire logic                     reg_wr_in,
   input  wire logic                     reg_rd_in,
   output logic      [31:0]              reg_rdata_out,
   input  wire vpf_pkg::vpf_req_s        req_in,
   output logic                          req_ready_out,
   output vpf_pkg::vpf_rsp_s             rsp_out,
   output logic      [3:0]               flags_out
);
   import vpf_pkg::*;

   if (LANES != VPF_LANES || EW != VPF_EW)
   begin : g_bad_geom
      $error("vpf_core: geometry must match the package");
   end

   // ----------------
   // State
   // ----------------
   typedef enum logic [1:0] {
      VPF_ST_IDLE = 2'b01,
      VPF_ST_HOLD = 2'b10
   } vpf_st_e;

   vpf_st_e           st_r;
   vpf_st_e           st_nxt;
   logic              ahp_r;
   logic              dit_r;
   logic [3:0]        bf_r;
   logic [3:0]        flags_r;
   logic [3:0]        flags_nxt;
   logic [VPF_PW-1:0] fm_r;
   logic [VPF_PW-1:0] fm_nxt;
   logic              ready_r;
   vpf_rsp_s          rsp_r;
   vpf_rsp_s          pend_r;
   vpf_rsp_s          calc;
   logic [31:0]       rdata_r;

   // ----------------
   // Decode
   // ----------------
   wire logic take;
   wire logic op_fm_rd;
   wire logic op_fm_wr;
   wire logic op_vec;
   wire logic op_fp;
   wire logic op_ct;
   wire logic low_only;
   wire logic bad_pg;
   wire logic bad_bf;
   wire logic illegal;

   assign take     = req_in.valid & ready_r;
   assign op_fm_rd = (req_in.op == VPF_OP_RDFM) | (req_in.op == VPF_OP_RDFMS);
   assign op_fm_wr = (req_in.op == VPF_OP_WRFM) | (req_in.op == VPF_OP_SETFM);
   assign op_fp    = (req_in.op == VPF_OP_FNEG16) | (req_in.op == VPF_OP_BFNEG);
   assign op_vec   = (req_in.op == VPF_OP_VADD) | op_fp;
   assign op_ct    = (req_in.op == VPF_OP_CTEQ) | (req_in.op == VPF_OP_CTNE);
   assign low_only = op_vec | (req_in.op == VPF_OP_CMPEQ) | (req_in.op == VPF_OP_LASTB);
   assign bad_pg   = req_in.predicated & low_only
                   & (req_in.pg_idx >= 4'(VPF_PRED_LOW_REGS));
   assign bad_bf   = (req_in.op == VPF_OP_BFNEG) & (bf_r == 4'h0);
   assign illegal  = bad_pg | bad_bf;

   // ----------------
   // Active lanes and per-lane sources
   // ----------------
   logic [LANES-1:0] act;
   logic [LANES-1:0] pa_b;
   logic [LANES-1:0] fm_b;
   logic [LANES-1:0] eq_b;
   logic [LANES-1:0] pres_b;
   logic [VPF_VW-1:0] vnew;
   logic [VPF_VW-1:0] vres;
   logic [VPF_PW-1:0] pnew;
   logic [VPF_PW-1:0] pres;
   logic [EW-1:0]     last_el;

   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         wire logic [EW-1:0] a_el;
         wire logic [EW-1:0] b_el;

         assign a_el = req_in.va[g*EW +: EW];
         assign b_el = req_in.vb[g*EW +: EW];
         assign act[g]  = req_in.predicated ? req_in.pg[2*g] : 1'b1;
         assign pa_b[g] = req_in.pa[2*g];
         assign fm_b[g] = fm_r[2*g];
         assign eq_b[g] = (a_el == b_el);
         assign pnew[2*g +: 2] = {1'b0, pres_b[g]};

         // Sign flip in the IEEE layout; the alternative format bit never
         // reaches this path
         assign vnew[g*EW +: EW] = op_fp ? (a_el ^ (EW'(1) << VPF_FP_SIGN))
                                         : EW'(a_el + b_el);

         vpf_lane #(.W(EW)) u_vlane
         (
            .act_in   (act[g]),
            .zero_in  (req_in.zeroing),
            .new_in   (vnew[g*EW +: EW]),
            .old_in   (req_in.vd_old[g*EW +: EW]),
            .lane_out (vres[g*EW +: EW])
         );

         vpf_lane #(.W(2)) u_plane
         (
            .act_in   (act[g]),
            .zero_in  (req_in.zeroing),
            .new_in   (pnew[2*g +: 2]),
            .old_in   (req_in.pd_old[2*g +: 2]),
            .lane_out (pres[2*g +: 2])
         );
      end
   endgenerate

   // Boolean predicate result per operation
   always_comb
   begin
      case (req_in.op)
         VPF_OP_RDFM,
         VPF_OP_RDFMS: pres_b = fm_b;
         VPF_OP_CMPEQ: pres_b = eq_b;
         default:      pres_b = pa_b;
      endcase
   end

   // Last active element for scalar extraction
   always_comb
   begin
      last_el = '0;
      for (int i = 0; i < LANES; i++)
      begin
         if (act[i])
            last_el = req_in.va[i*EW +: EW];
      end
   end

   // ----------------
   // Scalar placement
   // ----------------
   wire logic [VPF_RW-1:0] smask;
   wire logic [VPF_RW-1:0] scal;

   assign smask = (req_in.swidth == VPF_SW8)  ? 64'hFF :
                  (req_in.swidth == VPF_SW16) ? 64'hFFFF :
                  (req_in.swidth == VPF_SW32) ? 64'hFFFF_FFFF :
                                                '1;
   assign scal  = VPF_RW'(last_el) & smask;

   // ----------------
   // Condition flags
   // ----------------
   wire logic [3:0] pflags;
   wire logic       ct_hit;

   vpf_flag_gen #(.LANES(LANES)) u_flags
   (
      .res_in   (pres_b),
      .act_in   (act),
      .condition_flags_out (pflags)
   );

   assign ct_hit = (req_in.op == VPF_OP_CTEQ) ? (req_in.xa == req_in.xb)
                                              : (req_in.xa != req_in.xb);

   always_comb
   begin
      flags_nxt = flags_r;
      if (op_ct)
      begin
         flags_nxt[VPF_FN] = ct_hit;
         flags_nxt[VPF_FV] = ~ct_hit & ~flags_r[VPF_FC];
      end
      else if (req_in.set_flags || req_in.op == VPF_OP_PREDICATE_TEST || req_in.op == VPF_OP_RDFMS)
         flags_nxt = pflags;
   end

   // ----------------
   // Fault mask next value
   // ----------------
   always_comb
   begin
      case (req_in.op)
         VPF_OP_SETFM:  fm_nxt = VPF_FM_RST;
         VPF_OP_WRFM:   fm_nxt = req_in.pa;
         // Faulting active lanes clear mask bits; nothing sets them
         VPF_OP_FFLOAD:
         begin
            fm_nxt = fm_r;
            for (int i = 0; i < LANES; i++)
            begin
               if (act[i] && req_in.pa[2*i])
                  fm_nxt[2*i +: 2] = 2'b00;
            end
         end
         default:       fm_nxt = fm_r;
      endcase
   end

   // ----------------
   // Response
   // ----------------
   always_comb
   begin
      calc         = '0;
      calc.valid   = 1'b1;
      calc.illegal = illegal;
      calc.flags   = flags_r;
      if (!illegal)
      begin
         calc.flags = flags_nxt;
         if (op_vec)
            calc.vec = vres;
         if (req_in.op == VPF_OP_LASTB)
            calc.scalar = scal;
         if (req_in.op == VPF_OP_RDFM && !req_in.predicated)
            calc.pred = fm_r;
         else if (op_fm_rd || req_in.op == VPF_OP_CMPEQ)
            calc.pred = pres;
      end
   end

   // ----------------
   // Timing: the second cycle is taken only on data with work to do,
   // unless the timing control pins it
   // ----------------
   wire logic dit_on;
   wire logic data_slow;
   wire logic slow;

   assign dit_on    = HAS_GEN2 & dit_r;
   assign data_slow = op_vec & (|(req_in.va & req_in.vb));
   assign slow      = dit_on ? (~req_in.predicated | (|act))
                             : data_slow;

   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         VPF_ST_IDLE: if (take && slow) st_nxt = VPF_ST_HOLD;
         VPF_ST_HOLD: st_nxt = VPF_ST_IDLE;
         default:     st_nxt = VPF_ST_IDLE;
      endcase
   end

   // State and architectural updates happen at acceptance, one request
   // at a time, so every mask access is ordered by issue order
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         st_r    <= VPF_ST_IDLE;
         ready_r <= 1'b1;
         fm_r    <= VPF_FM_RST;
         flags_r <= VPF_FLAGS_RST;
         pend_r  <= '0;
         rsp_r   <= '0;
      end
      else
      begin
         st_r    <= st_nxt;
         ready_r <= (st_nxt == VPF_ST_IDLE);
         rsp_r   <= '0;
         if (st_r == VPF_ST_HOLD)
            rsp_r <= pend_r;
         if (take && !illegal)
         begin
            fm_r    <= fm_nxt;
            flags_r <= flags_nxt;
         end
         if (take && slow)
            pend_r <= calc;
         else if (take)
            rsp_r <= calc;
      end
   end

   // ----------------
   // Register port
   // ----------------
   wire logic        wr_ctrl;
   wire logic [31:0] rd_mux;

   assign wr_ctrl = reg_wr_in & (reg_addr_in == VPF_REG_CTRL);
   assign rd_mux  = (reg_addr_in == VPF_REG_CTRL)  ? {24'h0, bf_r, 2'h0, dit_r, ahp_r} :
                    (reg_addr_in == VPF_REG_FLAGS) ? {28'h0, flags_r} :
                                                     32'h0;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ahp_r   <= VPF_CTRL_RST[VPF_CTRL_AHP];
         dit_r   <= VPF_CTRL_RST[VPF_CTRL_DIT];
         bf_r    <= BF16_RESET;
         rdata_r <= 32'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ahp_r <= reg_wdata_in[VPF_CTRL_AHP];
            dit_r <= reg_wdata_in[VPF_CTRL_DIT];
            bf_r  <= reg_wdata_in[VPF_CTRL_BF_HI:VPF_CTRL_BF_LO];
         end
         rdata_r <= reg_rd_in ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata_out = rdata_r;
   assign req_ready_out = ready_r;
   assign rsp_out       = rsp_r;
   assign flags_out     = flags_r;

endmodule
`default_nettype wire

// ==== dv/vpf_core_asserts.sv ====
// Concurrent checks on the ports of the vector predication core.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module vpf_core_asserts
   import vpf_pkg::*;
#(
   parameter bit HAS_GEN2 = 1'b1
)
(
   input wire logic              clk_in,
   input wire logic              resetn_in,
   input wire logic [3:0]        reg_addr_in,
   input wire logic [31:0]       reg_wdata_in,
   input wire logic              reg_wr_in,
   input wire logic              reg_rd_in,
   input wire logic [31:0]       reg_rdata_out,
   input wire vpf_pkg::vpf_req_s req_in,
   input wire logic              req_ready_out,
   input wire vpf_pkg::vpf_rsp_s rsp_out,
   input wire logic [3:0]        flags_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   // -----------------------------------------------------------
   // Helper logic
   // -----------------------------------------------------------
   function automatic logic [7:0] ev(logic [15:0] p);
      for (int i = 0; i < 8; i++)
         ev[i] = p[2*i];
   endfunction

   function automatic logic [3:0] condition_flags(logic [7:0] res, logic [7:0] act);
      logic f;
      logic l;
      logic any;
      logic seen;
      {f, l, any, seen} = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (act[i])
         begin
            if (!seen)
               f = res[i];
            seen = 1'b1;
            l = res[i];
            any = any | res[i];
         end
      end
      return {f, ~any, ~l, 1'b0};
   endfunction

   logic       dit_r;
   logic       acc;
   logic       is_pt;
   logic       pg_none;
   logic [3:0] pt_exp;
   assign acc     = req_in.valid && req_ready_out;
   assign is_pt   = acc && (req_in.op == VPF_OP_PREDICATE_TEST);
   assign pg_none = (ev(req_in.pg) == 8'h00);
   assign pt_exp  = condition_flags(ev(req_in.pa), req_in.predicated ? ev(req_in.pg) : 8'hFF);

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         dit_r <= 1'b0;
      else if (reg_wr_in && (reg_addr_in == VPF_REG_CTRL))
         dit_r <= reg_wdata_in[VPF_CTRL_DIT];
   end

   sequence s_set_read;
      (acc && req_in.op == VPF_OP_SETFM) ##1
      (acc && req_in.op == VPF_OP_RDFM && !req_in.predicated);
   endsequence

   // -----------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
      else $error("read data without strobe");
   a_rsp_quiet: assert property (!rsp_out.valid |-> rsp_out == '0)
      else $error("idle response not zero");
   a_hold_once: assert property (!req_ready_out |-> $past(acc) ##1 req_ready_out)
      else $error("bad ready low");
   a_rsp_order: assert property (acc |-> ##[1:2] rsp_out.valid)
      else $error("response missing");
   a_predicate_test_first: assert property (is_pt |=> flags_out[VPF_FN] == $past(pt_exp[3]))
      else $error("first-lane flag wrong after predicate test");
   a_predicate_test_none: assert property (is_pt |=> flags_out[VPF_FZ] == $past(pt_exp[2]))
      else $error("none-active flag wrong after predicate test");
   a_predicate_test_last: assert property (is_pt |=> flags_out[VPF_FC] == $past(pt_exp[1]))
      else $error("last-lane flag wrong after predicate test");
   a_predicate_test_vclr: assert property (is_pt |=> !flags_out[VPF_FV])
      else $error("overflow flag not cleared after predicate test");
   a_fm_set_read: assert property (s_set_read |-> ##[1:2] (rsp_out.valid && ev(rsp_out.pred) == 8'hFF))
      else $error("mask not all ones after set");
   a_dit_slow: assert property (acc && dit_r && HAS_GEN2 && !req_in.predicated |=> !req_ready_out ##1 rsp_out.valid)
      else $error("unpredicated op not on fixed timing");
   a_dit_pred: assert property (acc && dit_r && HAS_GEN2 && req_in.predicated |=> req_ready_out == $past(pg_none))
      else $error("predicated timing wrong");
endmodule

bind vpf_core vpf_core_asserts #(.HAS_GEN2(HAS_GEN2)) u_asserts (.*);
`default_nettype wire

// ==== dv/vpf_core_tb.sv ====
// Self-checking bench for the vector predication core.
// Assumes the package, core and checker sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
module vpf_core_tb;
   import vpf_pkg::*;
   localparam logic [3:0]  BF_RST  = 4'h1; // Arbitrary nonzero feature value
   localparam logic [7:0]  EQ_MASK = 8'h29;
   localparam logic [4:0]  PT_P = 5'b11100;
   localparam logic [15:0] PT_G [5] = '{16'h0, 16'h0, 16'h0014, 16'h0, 16'h5000};
   localparam logic [15:0] PT_A [5] = '{16'h4001, 16'h0, 16'h0010, 16'hFFFF, 16'h1000};
   localparam logic [3:0]  PT_F [5] = '{4'h8, 4'h6, 4'h0, 4'h6, 4'hA};
   logic        clk_in;
   logic        resetn_in;
   logic [3:0]  reg_addr_in;
   logic [31:0] reg_wdata_in;
   logic        reg_wr_in;
   logic        reg_rd_in;
   logic [31:0] reg_rdata_out;
   vpf_req_s    req_in;
   logic        req_ready_out;
   vpf_rsp_s    rsp_out;
   logic [3:0]  flags_out;
   int          n_mismatch;
   int          tests_run;
   int          cyc;
   int          t_take;
   int          lat;
   vpf_rsp_s    rq[$];
   int          lq[$];
   vpf_rsp_s    rs;
   vpf_req_s    q;

   vpf_core #(.BF16_RESET(BF_RST)) u_dut (.*);

   // -----------------------------------------------------------
   // Clock, response monitor and helpers
   // -----------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   always @(negedge clk_in)
   begin
      cyc++;
      if (rsp_out.valid === 1'b1)
      begin
         rq.push_back(rsp_out);
         lq.push_back(cyc - t_take);
      end
   end

   function automatic logic [7:0] ev(logic [15:0] p);
      for (int i = 0; i < 8; i++)
         ev[i] = p[2*i];
   endfunction

   function automatic vpf_req_s mk(vpf_op_e op, logic p, logic z, logic [15:0] g, logic [15:0] a);
      mk = '0;
      mk.valid = 1'b1;
      mk.op = op;
      mk.predicated = p;
      mk.zeroing = z;
      mk.pg = g;
      mk.pa = a;
   endfunction

   function automatic logic [VPF_VW-1:0] vexp(vpf_req_s r);
      logic a;
      for (int i = 0; i < 8; i++)
      begin
         a = !r.predicated || r.pg[2*i];
         vexp[16*i +: 16] = a ? r.va[16*i +: 16] + r.vb[16*i +: 16]
                              : (r.zeroing ? 16'h0 : r.vd_old[16*i +: 16]);
      end
   endfunction

   task automatic chk(logic [127:0] seen, logic [127:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic reg_rd(logic [3:0] a, logic [31:0] e);
      @(posedge clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk(reg_rdata_out, e);
   endtask

   // Holds the request until an edge where ready is high
   task automatic issue(vpf_req_s r);
      logic rdy;
      int   n;
      req_in <= r;
      n = 0;
      do
      begin
         @(negedge clk_in);
         rdy = req_ready_out;
         @(posedge clk_in);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1)
         n_mismatch++;
      t_take = cyc;
   endtask

   task automatic fin(int k);
      int n;
      req_in <= '0;
      n = 0;
      while (rq.size() < k && n < 20)
      begin
         @(negedge clk_in);
         n++;
      end
      if (rq.size() < k)
         n_mismatch++;
   endtask

   task automatic pop();
      rs = (rq.size() > 0) ? rq.pop_front() : '0;
      lat = (lq.size() > 0) ? lq.pop_front() : 0;
   endtask

   task automatic run(vpf_req_s r);
      @(posedge clk_in);
      issue(r);
      fin(1);
      pop();
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #20000;
      n_mismatch++;
      end_of_test();
   end

   // -----------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------
   initial
   begin
      {resetn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      req_in = '0;
      {n_mismatch, tests_run, cyc, t_take} = '0;
      repeat (12) @(posedge clk_in);
      resetn_in <= 1'b1;
      reg_rd(VPF_REG_CTRL, {24'h0, BF_RST, 4'h0});
      reg_rd(VPF_REG_FLAGS, 32'h0);
      reg_wr(VPF_REG_CTRL, 32'hFFFF_FFFF);
      reg_rd(VPF_REG_CTRL, 32'h0000_00F3);
      reg_wr(VPF_REG_FLAGS, 32'h0000_000F);
      reg_rd(VPF_REG_FLAGS, 32'h0);
      reg_rd(4'h8, 32'h0);
      reg_wr(VPF_REG_CTRL, 32'h0000_0011);
      $display("Test registers done");
      run(mk(VPF_OP_RDFM, 1'b0, 1'b0, 16'h0, 16'h0));
      chk(ev(rs.pred), 8'hFF);
      @(posedge clk_in);
      issue(mk(VPF_OP_WRFM, 1'b0, 1'b0, 16'h0, 16'h0115));
      issue(mk(VPF_OP_RDFMS, 1'b1, 1'b1, 16'h5555, 16'h0));
      fin(2);
      pop();
      pop();
      chk(ev(rs.pred), 8'h17);
      chk(rs.flags, 4'hA);
      q = mk(VPF_OP_RDFM, 1'b1, 1'b0, 16'h0055, 16'h0);
      q.pd_old = 16'h5500;
      run(q);
      chk(ev(rs.pred), 8'hF7);
      q.zeroing = 1'b1;
      run(q);
      chk(ev(rs.pred), 8'h07);
      run(mk(VPF_OP_FFLOAD, 1'b1, 1'b0, 16'h5555, 16'h0004));
      run(mk(VPF_OP_RDFM, 1'b0, 1'b0, 16'h0, 16'h0));
      chk(ev(rs.pred), 8'h15);
      @(posedge clk_in);
      issue(mk(VPF_OP_SETFM, 1'b0, 1'b0, 16'h0, 16'h0));
      issue(mk(VPF_OP_RDFM, 1'b0, 1'b0, 16'h0, 16'h0));
      fin(2);
      pop();
      pop();
      chk(ev(rs.pred), 8'hFF);
      $display("Test fault mask done");
      for (int i = 0; i < 5; i++)
      begin
         run(mk(VPF_OP_PREDICATE_TEST, PT_P[i], 1'b0, PT_G[i], PT_A[i]));
         chk(rs.flags, PT_F[i]);
         chk(flags_out, PT_F[i]);
      end
      $display("Test predicate flags done");
      q = mk(VPF_OP_CMPEQ, 1'b1, 1'b1, 16'h0555, 16'h0);
      q.set_flags = 1'b1;
      q.pd_old = 16'hFFFF;
      for (int i = 0; i < 8; i++)
      begin
         q.va[16*i +: 16] = 16'(i);
         q.vb[16*i +: 16] = 16'(i) ^ 16'(!EQ_MASK[i]);
      end
      run(q);
      chk(ev(rs.pred), EQ_MASK);
      chk(rs.flags, 4'h8);
      q.zeroing = 1'b0;
      run(q);
      chk(ev(rs.pred), 8'hE9);
      q.predicated = 1'b0;
      run(q);
      chk(ev(rs.pred), EQ_MASK);
      chk(rs.flags, 4'hA);
      q.predicated = 1'b1;
      q.pg_idx = 4'h8;
      run(q);
      chk(rs.illegal, 1'b1);
      chk(flags_out, 4'hA);
      $display("Test compare done");
      q = mk(VPF_OP_VADD, 1'b1, 1'b0, 16'h5050, 16'h0);
      for (int i = 0; i < 8; i++)
      begin
         q.va[16*i +: 16] = 16'(i + 1);
         q.vb[16*i +: 16] = 16'h0100;
         q.vd_old[16*i +: 16] = 16'hEEE0 | 16'(i);
      end
      for (int m = 0; m < 3; m++)
      begin
         q.zeroing = (m == 1);
         q.predicated = (m < 2);
         run(q);
         chk(rs.vec, vexp(q));
         chk(lat, 1);
      end
      $display("Test lane select done");
      q = mk(VPF_OP_FNEG16, 1'b0, 1'b0, 16'h0, 16'h0);
      q.va = {8{16'h3C00}};
      run(q);
      chk(rs.vec, {8{16'hBC00}});
      q.op = VPF_OP_BFNEG;
      run(q);
      chk({rs.illegal, rs.vec}, {1'b0, {8{16'hBC00}}});
      reg_wr(VPF_REG_CTRL, 32'h0000_0001);
      run(q);
      chk({rs.illegal, rs.vec}, {1'b1, 128'h0});
      reg_wr(VPF_REG_CTRL, {24'h0, BF_RST, 4'h0});
      $display("Test float gating done");
      q = mk(VPF_OP_LASTB, 1'b1, 1'b0, 16'h1555, 16'h0);
      q.va = {16'h1111, 16'hABCD, 96'h0};
      for (int w = 0; w < 4; w++)
      begin
         q.swidth = 2'(w);
         run(q);
         chk(rs.scalar, (w == 0) ? 64'hCD : 64'hABCD);
      end
      $display("Test scalar placement done");
      run(mk(VPF_OP_PREDICATE_TEST, 1'b0, 1'b0, 16'h0, 16'h0));
      q = mk(VPF_OP_CTEQ, 1'b0, 1'b0, 16'h0, 16'h0);
      q.xa = 64'h5;
      q.xb = 64'h5;
      run(q);
      chk(flags_out, 4'hE);
      q.op = VPF_OP_CTNE;
      run(q);
      chk(flags_out, 4'h6);
      run(mk(VPF_OP_PREDICATE_TEST, 1'b0, 1'b0, 16'h0, 16'h4001));
      q.xb = 64'h6;
      run(q);
      chk(flags_out, 4'h8);
      q.op = VPF_OP_CTEQ;
      run(q);
      chk(flags_out, 4'h1);
      $display("Test compare-terminate done");
      q = mk(VPF_OP_VADD, 1'b0, 1'b0, 16'h0, 16'h0);
      q.va = {8{16'h00F0}};
      run(q);
      chk(lat, 1);
      q.vb = {8{16'h0FF0}};
      run(q);
      chk(lat, 2);
      reg_wr(VPF_REG_CTRL, {24'h0, BF_RST, 4'h2});
      run(q);
      chk(lat, 2);
      q.vb = '0;
      run(q);
      chk(lat, 2);
      q.predicated = 1'b1;
      q.pg = 16'h0001;
      run(q);
      chk(lat, 2);
      q.vb = {8{16'h0FF0}};
      run(q);
      chk(lat, 2);
      $display("Test fixed timing done");
      end_of_test();
   end
endmodule
`default_nettype wire
